// ==== hw/hfsc_addr.sv ====
// Purpose: first address byte match for the receiver
// Assumes: byte presented with a one-cycle strobe
// Notes: combinational compare, registered by the caller
`timescale 1ns/10ps
module hfsc_addr
    import hfsc_pkg::*;
(
    input wire logic seven_mode,
    input wire logic [7:0] rx_byte,
    input wire logic [7:0] own_addr,
    output logic match
);
    // seven-bit mode ignores bit 0 of the address but demands it set
    always_comb
    begin
        if (seven_mode)
            match = (rx_byte[7:1] == own_addr[7:1]) && rx_byte[0]; // see R4 see R5
        else
            match = (rx_byte == own_addr);
    end
endmodule : hfsc_addr

// ==== hw/hfsc_fifo.sv ====
// Purpose: byte fifo whose pointers can be flushed without clearing storage
// Assumes: one clock, synchronous reset
// Notes: flush moves occupancy to empty, or to one word if a write lands in the same cycle; memory words keep their values
`timescale 1ns/10ps
module hfsc_fifo
    import hfsc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed
    {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
    } hfsc_fifo_st_t;
    hfsc_fifo_st_t st_reg;
    hfsc_fifo_st_t st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // ready is kept in a flop so a top-level port can come straight from it
    assign in_ready = st_reg.rdy;
    assign out_valid = (st_reg.cnt != '0);
    assign out_data = mem[st_reg.rp];
    assign level = st_reg.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready && !flush;

    // pointer update; flush drops occupancy only
    always_comb
    begin
        st_next = st_reg;
        if (flush)
        begin
            // a write in the flush cycle still lands, as the first word after it
            st_next.rp = st_reg.wp;
            st_next.cnt = {{AW{1'b0}}, push};
            if (push)
                st_next.wp = st_reg.wp + 1'b1;
        end
        else
        begin
            if (push)
                st_next.wp = st_reg.wp + 1'b1;
            if (pop)
                st_next.rp = st_reg.rp + 1'b1;
            st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
        st_next.rdy = (st_next.cnt != DEPTH[AW:0]);
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_reg <= '0;
            st_reg.rdy <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // storage has no reset, so a flush cannot wipe it
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[st_reg.wp] <= in_data;
    end
endmodule : hfsc_fifo

// ==== hw/hfsc_pkg.sv ====
// Purpose: shared constants for the link fifo status and control block
// Assumes: 8-bit register port, byte-wide fifos
// Notes: offsets are the register addresses within one page
package hfsc_pkg;
    localparam logic [7:0] HFSC_OFS_STATE = 8'h14;
    localparam logic [7:0] HFSC_OFS_CTRL2 = 8'h15;
    // control register field positions
    localparam int HFSC_B_INTSEL = 7;
    localparam int HFSC_B_CYCLE = 6;
    localparam int HFSC_B_CRCINH = 5;
    localparam int HFSC_B_SEVEN = 4;
    localparam int HFSC_B_RXFRST = 1;
    localparam int HFSC_B_TXFRST = 0;
    localparam logic [7:0] HFSC_CTRL2_RESET = 8'h00;
    localparam logic [7:0] HFSC_CTRL2_WMASK = 8'hF3;
    // fifo status codes
    localparam logic [1:0] HFSC_TX_FULL = 2'h0;
    localparam logic [1:0] HFSC_TX_ATTH = 2'h1;
    localparam logic [1:0] HFSC_TX_EMPTY = 2'h2;
    localparam logic [1:0] HFSC_TX_BELOW = 2'h3;
    localparam logic [1:0] HFSC_RX_EMPTY = 2'h0;
    localparam logic [1:0] HFSC_RX_BELOW = 2'h1;
    localparam logic [1:0] HFSC_RX_FULL = 2'h2;
    localparam logic [1:0] HFSC_RX_ATTH = 2'h3;
    // abort counts only once this many packet bits have arrived
    localparam logic [4:0] HFSC_ABORT_MIN_BITS = 5'd26;
    localparam int HFSC_FIFO_DEPTH = 16;
    localparam int HFSC_FIFO_WIDTH = 8;
    localparam logic [4:0] HFSC_THRESH_RESET = 5'h08;
    localparam logic [7:0] HFSC_RESET_BYTE = 8'h00;
    localparam logic [7:0] HFSC_BCNT_RESET = 8'h00;
endpackage : hfsc_pkg

// ==== hw/hfsc_top.sv ====
// Purpose: fifo status register and second control register of one link controller page
// Assumes: host register port with one-cycle read and write strobes, single clock
// Notes: the tx fifo sits between host writes and the transmitter reads
//
// Summary of operation
// R1 - select bit chooses underrun or received abort for status bit 2
// R2 - cycling bit makes tx byte counter reload its loaded count repeatedly
// R3 - crc inhibit stops the check sequence after an end-of-packet byte
// R4 - seven-bit mode compares only seven bits of the first address byte
// R5 - seven-bit mode needs received address bit 0 set
// R6 - rx fifo reset clears pointers; status then shows rx fifo empty
// R7 - rx fifo reset disables receiver until the next flag arrives
// R8 - rx fifo reset leaves the stored data bytes untouched
// R9 - tx fifo reset empties the tx fifo in the status register
// R10 - tx fifo reset bit clears itself on the next host write to the fifo
// R11 - tx fifo reset leaves the stored data bytes untouched
// R12 - host writes zero to reserved control bits 3 and 2
// R13 - underrun event when the transmitter reads an empty tx fifo
// R14 - received abort counts only after at least 26 packet bits
// R15 - all writable control bits are zero after reset
`timescale 1ns/10ps
module hfsc_top
    import hfsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic tx_fifo_wr,
    input wire logic [7:0] tx_fifo_wdata,
    input wire logic packet_end_tag,
    output logic tx_fifo_ready,
    input wire logic tx_fetch,
    output logic [7:0] tx_byte,
    output logic tx_byte_end,
    output logic tx_byte_valid,
    output logic tx_append_fcs,
    input wire logic [4:0] tx_threshold,
    input wire logic [4:0] rx_threshold,
    input wire logic [7:0] tx_count_load,
    output logic [7:0] tx_count,
    input wire logic rx_flag_seen,
    input wire logic rx_bit_strobe,
    input wire logic rx_abort_seen,
    input wire logic rx_byte_wr,
    input wire logic [7:0] rx_byte,
    input wire logic rx_first_byte,
    input wire logic [7:0] own_addr,
    input wire logic rx_fifo_rd,
    output logic [7:0] rx_fifo_rdata,
    output logic rx_enabled,
    output logic addr_match,
    output logic frame_abort_flag
);
    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [7:0] rdata;
        logic rx_en;
        logic [4:0] bitcnt;
        logic [7:0] bcnt;
        logic [7:0] txb;
        logic txe;
        logic txv;
        logic fcs;
        logic match;
        logic ev2;
        logic [7:0] rxd;
    } hfsc_st_t;
    hfsc_st_t st_reg;
    hfsc_st_t st_next;

    logic [8:0] tx_out;
    logic tx_ovalid;
    logic [4:0] tx_lvl;
    logic [4:0] rx_lvl;
    logic rx_in_ready;
    logic rx_ovalid;
    logic [7:0] rx_odata;
    logic amatch;
    logic [1:0] tx_code;
    logic [1:0] rx_code;
    logic wr_ctrl;

    assign wr_ctrl = reg_wr && (reg_addr == HFSC_OFS_CTRL2);

    // tx fifo carries the end tag as a ninth bit
    hfsc_fifo #(.WIDTH(HFSC_FIFO_WIDTH + 1), .DEPTH(HFSC_FIFO_DEPTH)) u_txf
    (
        .core_clk(core_clk),
        .srst(srst),
        .flush(st_reg.ctrl[HFSC_B_TXFRST]), // see R9 see R11
        .in_valid(tx_fifo_wr),
        .in_ready(tx_fifo_ready),
        .in_data({packet_end_tag, tx_fifo_wdata}),
        .out_valid(tx_ovalid),
        .out_ready(tx_fetch),
        .out_data(tx_out),
        .level(tx_lvl)
    );

    hfsc_fifo #(.WIDTH(HFSC_FIFO_WIDTH), .DEPTH(HFSC_FIFO_DEPTH)) u_rxf
    (
        .core_clk(core_clk),
        .srst(srst),
        .flush(st_reg.ctrl[HFSC_B_RXFRST]), // see R6 see R8
        .in_valid(rx_byte_wr && st_reg.rx_en && !rx_first_byte && !st_reg.ctrl[HFSC_B_RXFRST]), // see R7
        .in_ready(rx_in_ready),
        .in_data(rx_byte),
        .out_valid(rx_ovalid),
        .out_ready(rx_fifo_rd),
        .out_data(rx_odata),
        .level(rx_lvl)
    );

    hfsc_addr u_addr
    (
        .seven_mode(st_reg.ctrl[HFSC_B_SEVEN]),
        .rx_byte(rx_byte),
        .own_addr(own_addr),
        .match(amatch)
    );

    // map occupancy onto the two-bit status codes
    always_comb
    begin
        if (tx_lvl == '0)
            tx_code = HFSC_TX_EMPTY; // see R9
        else if (tx_lvl == 5'(HFSC_FIFO_DEPTH))
            tx_code = HFSC_TX_FULL;
        else if (tx_lvl >= tx_threshold)
            tx_code = HFSC_TX_ATTH;
        else
            tx_code = HFSC_TX_BELOW;
        if (rx_lvl == '0)
            rx_code = HFSC_RX_EMPTY; // see R6
        else if (!rx_in_ready)
            rx_code = HFSC_RX_FULL;
        else if (rx_lvl >= rx_threshold)
            rx_code = HFSC_RX_ATTH;
        else
            rx_code = HFSC_RX_BELOW;
    end

    // next state of all control and status
    always_comb
    begin
        st_next = st_reg;
        st_next.ev2 = 1'b0;
        st_next.txv = 1'b0;
        st_next.fcs = 1'b0;
        // host write; reserved bits forced to zero
        if (wr_ctrl)
            st_next.ctrl = reg_wdata & HFSC_CTRL2_WMASK; // see R12
        else
            st_next.ctrl[HFSC_B_RXFRST] = 1'b0;
        // tx reset holds until a host byte arrives
        if (tx_fifo_wr && !wr_ctrl)
            st_next.ctrl[HFSC_B_TXFRST] = 1'b0; // see R10
        // rx reset stops the receiver, a flag restarts it
        if (st_reg.ctrl[HFSC_B_RXFRST])
            st_next.rx_en = 1'b0; // see R7
        else if (rx_flag_seen)
            st_next.rx_en = 1'b1;
        // packet bit counter saturates at the abort threshold
        if (rx_flag_seen)
            st_next.bitcnt = '0;
        else if (rx_bit_strobe && st_reg.bitcnt != HFSC_ABORT_MIN_BITS)
            st_next.bitcnt = st_reg.bitcnt + 5'd1;
        // status bit 2 meaning follows the select bit
        if (st_reg.ctrl[HFSC_B_INTSEL])
            st_next.ev2 = tx_fetch && !tx_ovalid; // see R1 see R13
        else
            st_next.ev2 = rx_abort_seen && st_reg.rx_en
                && st_reg.bitcnt == HFSC_ABORT_MIN_BITS; // see R1 see R14
        // transmitter byte hand-off
        if (tx_fetch && tx_ovalid)
        begin
            st_next.txb = tx_out[7:0];
            st_next.txe = tx_out[8];
            st_next.txv = 1'b1;
            st_next.fcs = tx_out[8] && !st_reg.ctrl[HFSC_B_CRCINH]; // see R3
            if (st_reg.bcnt != '0)
                st_next.bcnt = st_reg.bcnt - 8'd1;
            else if (st_reg.ctrl[HFSC_B_CYCLE])
                st_next.bcnt = tx_count_load; // see R2
        end
        if (tx_count_load != st_reg.bcnt && st_reg.bcnt == '0 && !st_reg.ctrl[HFSC_B_CYCLE] && wr_ctrl)
            st_next.bcnt = tx_count_load;
        if (rx_byte_wr && rx_first_byte)
            st_next.match = amatch; // see R4 see R5
        if (rx_fifo_rd && rx_ovalid)
            st_next.rxd = rx_odata;
        // read data
        if (reg_rd && reg_addr == HFSC_OFS_STATE)
            st_next.rdata = {4'h0, tx_code, rx_code};
        else if (reg_rd && reg_addr == HFSC_OFS_CTRL2)
            st_next.rdata = st_reg.ctrl;
        else if (reg_rd)
            st_next.rdata = HFSC_RESET_BYTE;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_reg <= '0;
            st_reg.ctrl <= HFSC_CTRL2_RESET; // see R15
        end
        else
            st_reg <= st_next;
    end

    assign reg_rdata = st_reg.rdata;
    assign tx_byte = st_reg.txb;
    assign tx_byte_end = st_reg.txe;
    assign tx_byte_valid = st_reg.txv;
    assign tx_append_fcs = st_reg.fcs;
    assign tx_count = st_reg.bcnt;
    assign rx_enabled = st_reg.rx_en;
    assign addr_match = st_reg.match;
    assign frame_abort_flag = st_reg.ev2;
    assign rx_fifo_rdata = st_reg.rxd;

    property p_rxrst_off;
        @(posedge core_clk) disable iff (srst)
        st_reg.ctrl[HFSC_B_RXFRST] |=> !rx_enabled;
    endproperty
    a_rxrst_off: assert property (p_rxrst_off) else $error("receiver not disabled by rx reset"); // see R7

    property p_txrst_clear;
        @(posedge core_clk) disable iff (srst)
        st_reg.ctrl[HFSC_B_TXFRST] && tx_fifo_wr && !wr_ctrl |=> !st_reg.ctrl[HFSC_B_TXFRST];
    endproperty
    a_txrst_clear: assert property (p_txrst_clear) else $error("tx reset bit did not self clear"); // see R10

    property p_fcs;
        @(posedge core_clk) disable iff (srst)
        tx_fetch && tx_ovalid && tx_out[8] |=> tx_append_fcs == !$past(st_reg.ctrl[HFSC_B_CRCINH]);
    endproperty
    a_fcs: assert property (p_fcs) else $error("fcs append wrong"); // see R3

    property p_under;
        @(posedge core_clk) disable iff (srst)
        st_reg.ctrl[HFSC_B_INTSEL] && tx_fetch && !tx_ovalid |=> frame_abort_flag;
    endproperty
    a_under: assert property (p_under) else $error("underrun not flagged"); // see R13

    property p_early_abort;
        @(posedge core_clk) disable iff (srst)
        !st_reg.ctrl[HFSC_B_INTSEL] && st_reg.bitcnt < HFSC_ABORT_MIN_BITS |=> !frame_abort_flag;
    endproperty
    a_early_abort: assert property (p_early_abort) else $error("early abort flagged"); // see R14

    property p_rx_empty;
        @(posedge core_clk) disable iff (srst)
        st_reg.ctrl[HFSC_B_RXFRST] |=> rx_lvl == '0;
    endproperty
    a_rx_empty: assert property (p_rx_empty) else $error("rx fifo not empty after reset"); // see R6

    property p_tx_empty;
        @(posedge core_clk) disable iff (srst)
        st_reg.ctrl[HFSC_B_TXFRST] |=> tx_lvl == 5'($past(tx_fifo_wr && tx_fifo_ready));
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("tx fifo not empty after reset"); // see R9

    property p_seven;
        @(posedge core_clk) disable iff (srst)
        rx_byte_wr && rx_first_byte && st_reg.ctrl[HFSC_B_SEVEN] && !rx_byte[0] |=> !addr_match;
    endproperty
    a_seven: assert property (p_seven) else $error("seven-bit address with bit 0 clear matched"); // see R5

    property p_rsv;
        @(posedge core_clk) disable iff (srst)
        st_reg.ctrl[3:2] == 2'b00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set"); // see R12

    // a disabled receiver must not grow the rx fifo
    sequence s_rx_blocked;
        !st_reg.rx_en && rx_byte_wr;
    endsequence
    property p_rx_gate;
        @(posedge core_clk) disable iff (srst)
        s_rx_blocked |=> rx_lvl <= $past(rx_lvl);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("disabled receiver stored a byte"); // see R7

    // cycling: a fetch at zero count reloads the loaded value
    sequence s_fetch_at_zero;
        st_reg.ctrl[HFSC_B_CYCLE] && tx_fetch && tx_ovalid && st_reg.bcnt == '0;
    endsequence
    property p_cycle_reload;
        @(posedge core_clk) disable iff (srst)
        s_fetch_at_zero |=> tx_count == $past(tx_count_load);
    endproperty
    a_cycle_reload: assert property (p_cycle_reload) else $error("byte count did not reload"); // see R2

    // seven-bit mode with bit 0 set matches on the upper seven bits only
    property p_seven_cmp;
        @(posedge core_clk) disable iff (srst)
        rx_byte_wr && rx_first_byte && st_reg.ctrl[HFSC_B_SEVEN] && rx_byte[0]
            |=> addr_match == ($past(rx_byte[7:1]) == $past(own_addr[7:1]));
    endproperty
    a_seven_cmp: assert property (p_seven_cmp) else $error("seven-bit address compare wrong"); // see R4
endmodule : hfsc_top

// ==== testbench/hfsc_host_model.sv ====
// Purpose: host processor model on the register port of the link block
// Assumes: one-cycle strobes, read data registered one cycle after the strobe
// Notes: reserved control bits always go out as zero; idle bus shows inverted values
`timescale 1ns/10ps
module hfsc_host_model
    import hfsc_pkg::*;
(
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // quiet bus at time zero
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // write one register; released lines flip so no stale value lingers
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        #1;
        reg_addr = addr;
        reg_wdata = (addr == HFSC_OFS_CTRL2) ? (data & HFSC_CTRL2_WMASK) : data;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~reg_wdata;
    endtask : wr

    // read one register; data is taken after the edge that answered
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        #1;
        reg_addr = addr;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~addr;
        data = reg_rdata;
    endtask : rd
endmodule : hfsc_host_model

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the link fifo status and control block
// Assumes: 100 MHz core clock, inputs driven 1 ns after the rising edge
// Notes: event pulses are counted by monitors so latency slips stay visible
`timescale 1ns/10ps
module tb;
    import hfsc_pkg::*;
    logic core_clk = 1'b0, srst = 1'b1;
    logic reg_wr, reg_rd, tx_fifo_wr, packet_end_tag, tx_fifo_ready, tx_fetch, tx_byte_end, tx_byte_valid;
    logic tx_append_fcs, rx_flag_seen, rx_bit_strobe, rx_abort_seen, rx_byte_wr, rx_first_byte, rx_fifo_rd;
    logic rx_enabled, addr_match, frame_abort_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_fifo_wdata, tx_byte, tx_count_load, tx_count;
    logic [7:0] rx_byte, own_addr, rx_fifo_rdata, d, v, b, first_rx;
    logic [4:0] tx_threshold, rx_threshold;
    int error_cnt = 0, samples_checked = 0, cyc = 0, fa_cnt = 0, fcs_cnt = 0, k, f0;
    // bit strobes before the abort: one short of the minimum, exact, and well above
    int f0_tab[3] = '{25, 26, 38};

    hfsc_top dut (.core_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .tx_fifo_wr,
        .tx_fifo_wdata, .packet_end_tag, .tx_fifo_ready, .tx_fetch, .tx_byte, .tx_byte_end, .tx_byte_valid,
        .tx_append_fcs, .tx_threshold, .rx_threshold, .tx_count_load, .tx_count, .rx_flag_seen,
        .rx_bit_strobe, .rx_abort_seen, .rx_byte_wr, .rx_byte, .rx_first_byte, .own_addr, .rx_fifo_rd,
        .rx_fifo_rdata, .rx_enabled, .addr_match, .frame_abort_flag);
    hfsc_host_model host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);

    // clock, event monitors and the hang limit
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (frame_abort_flag === 1'b1) fa_cnt++;
        if (tx_append_fcs === 1'b1) fcs_cnt++;
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wrap_up;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task tx_put(input logic [7:0] data, input logic tag);
        tick(1);
        tx_fifo_wr = 1'b1;
        tx_fifo_wdata = data;
        packet_end_tag = tag;
        tick(1);
        tx_fifo_wr = 1'b0;
    endtask : tx_put

    task fetch;
        tick(1);
        tx_fetch = 1'b1;
        tick(1);
        tx_fetch = 1'b0;
    endtask : fetch

    // opening flag, then an address byte with the first-byte marker
    task rx_open(input logic [7:0] a);
        tick(1);
        rx_flag_seen = 1'b1;
        tick(1);
        rx_flag_seen = 1'b0;
        rx_byte_wr = 1'b1;
        rx_first_byte = 1'b1;
        rx_byte = a;
        tick(1);
        rx_byte_wr = 1'b0;
        rx_first_byte = 1'b0;
        tick(1);
    endtask : rx_open

    function logic exp_match(input logic s, input logic [7:0] r, input logic [7:0] o);
        return s ? (r[7:1] == o[7:1] && r[0]) : (r == o);
    endfunction : exp_match

    // cycling count after fetch j: loaded value down to zero, then reload
    function logic [7:0] exp_count(input int j, input int n);
        return 8'(n - (j % (n + 1)));
    endfunction : exp_count

    initial
    begin
        {tx_fifo_wr, packet_end_tag, tx_fetch, rx_flag_seen, rx_bit_strobe} = 5'h0_0;
        {rx_abort_seen, rx_byte_wr, rx_first_byte, rx_fifo_rd} = 4'h0;
        tx_fifo_wdata = 8'h00;
        rx_byte = 8'h00;
        void'($urandom(90));
        tx_threshold = 5'($urandom_range(15, 1));
        rx_threshold = 5'($urandom_range(15, 1));
        // held at zero until the cycling test so no control write preloads the counter
        tx_count_load = 8'h00;
        own_addr = 8'($urandom()) & 8'hFE;
        tick(10);
        srst = 1'b0;
        // reset state of control, status and receiver
        host.rd(HFSC_OFS_CTRL2, d);
        chk(d, HFSC_CTRL2_RESET);
        host.rd(HFSC_OFS_STATE, d);
        chk({4'h0, d[3:0]}, {4'h0, HFSC_TX_EMPTY, HFSC_RX_EMPTY});
        chk({7'h0, rx_enabled}, 8'h00);
        // random control values read back; rx reset bit left out since it self-clears
        repeat (6)
        begin
            v = 8'($urandom()) & 8'hF1;
            host.wr(HFSC_OFS_CTRL2, v);
            host.rd(HFSC_OFS_CTRL2, d);
            chk(d, v);
        end
        // fill with 14 to 16 bytes, flush, then one write clears the reset bit and is fetched first
        host.wr(HFSC_OFS_CTRL2, 8'h00);
        k = $urandom_range(16, 14);
        repeat (k) tx_put(8'($urandom()), 1'b0);
        host.rd(HFSC_OFS_STATE, d);
        chk({7'h0, d[3:2] != HFSC_TX_EMPTY}, 8'h01);
        chk({7'h0, tx_fifo_ready}, {7'h0, k < 16});
        host.wr(HFSC_OFS_CTRL2, 8'h01);
        host.rd(HFSC_OFS_STATE, d);
        chk({6'h0, d[3:2]}, {6'h0, HFSC_TX_EMPTY});
        host.rd(HFSC_OFS_CTRL2, d);
        chk(d, 8'h01);
        b = 8'($urandom());
        tx_put(b, 1'b0);
        host.rd(HFSC_OFS_CTRL2, d);
        chk(d, 8'h00);
        fetch();
        chk(tx_byte, b);
        chk({7'h0, tx_byte_valid}, 8'h01);
        // end-tagged byte with and without check sequence
        for (int i = 0; i < 2; i++)
        begin
            host.wr(HFSC_OFS_CTRL2, i ? 8'h20 : 8'h00);
            f0 = fcs_cnt;
            tx_put(8'($urandom()), 1'b1);
            fetch();
            chk({7'h0, tx_byte_end}, 8'h01);
            tick(3);
            chk(8'(fcs_cnt - f0), i ? 8'h00 : 8'h01);
        end
        // fetch from the empty fifo under both selections
        for (int i = 0; i < 2; i++)
        begin
            host.wr(HFSC_OFS_CTRL2, i ? 8'h80 : 8'h00);
            f0 = fa_cnt;
            fetch();
            tick(3);
            chk(8'(fa_cnt - f0), i ? 8'h01 : 8'h00);
        end
        // cycling counter: load, count down to zero, reload
        host.wr(HFSC_OFS_CTRL2, 8'h40);
        k = $urandom_range(5, 2);
        tx_count_load = 8'(k);
        repeat (k + 2) tx_put(8'($urandom()), 1'b0);
        for (int j = 0; j < k + 2; j++)
        begin
            fetch();
            chk(tx_count, exp_count(j, k));
        end
        // abort after too few and after enough packet bits
        host.wr(HFSC_OFS_CTRL2, 8'h00);
        foreach (f0_tab[i])
        begin
            f0 = fa_cnt;
            rx_open(own_addr);
            chk({7'h0, rx_enabled}, 8'h01);
            rx_bit_strobe = 1'b1;
            tick(f0_tab[i]);
            rx_bit_strobe = 1'b0;
            rx_abort_seen = 1'b1;
            tick(1);
            rx_abort_seen = 1'b0;
            tick(3);
            chk(8'(fa_cnt - f0), {7'h0, f0_tab[i] >= 26});
        end
        // address match in both modes, with bit 0 and high bit variants
        for (int i = 0; i < 8; i++)
        begin
            host.wr(HFSC_OFS_CTRL2, (i & 1) ? 8'h10 : 8'h00);
            b = (i < 2) ? own_addr : (i < 4) ? (own_addr | 8'h01) : (i < 6) ? (own_addr ^ 8'h81) : 8'($urandom());
            rx_open(b);
            chk({7'h0, addr_match}, {7'h0, exp_match(i & 1, b, own_addr)});
        end
        // store bytes, then rx fifo reset empties it and stops the receiver
        first_rx = 8'($urandom());
        tick(1);
        rx_byte_wr = 1'b1;
        rx_byte = first_rx;
        repeat (2)
        begin
            tick(1);
            rx_byte = 8'($urandom());
        end
        tick(1);
        rx_byte_wr = 1'b0;
        // oldest byte comes out first, two stay behind
        rx_fifo_rd = 1'b1;
        tick(1);
        rx_fifo_rd = 1'b0;
        chk(rx_fifo_rdata, first_rx);
        host.rd(HFSC_OFS_STATE, d);
        chk({7'h0, d[1:0] != HFSC_RX_EMPTY}, 8'h01);
        host.wr(HFSC_OFS_CTRL2, 8'h02);
        host.rd(HFSC_OFS_STATE, d);
        chk({6'h0, d[1:0]}, {6'h0, HFSC_RX_EMPTY});
        chk({7'h0, rx_enabled}, 8'h00);
        // the next flag restarts the receiver; the address byte is not stored
        rx_open(own_addr);
        chk({7'h0, rx_enabled}, 8'h01);
        host.rd(HFSC_OFS_STATE, d);
        chk({6'h0, d[1:0]}, {6'h0, HFSC_RX_EMPTY});
        wrap_up();
    end
endmodule : tb
